// >>> shared/dpcm_map.vh
`ifndef DPCM_MAP_VH
`define DPCM_MAP_VH

// ************************************************
// APB register offsets (byte addresses)
// ************************************************
`define DPCM_OFF_PLANE_CONTROL_FIRST  12'h000
`define DPCM_OFF_PLANE_CONTROL_THIRD  12'h004
`define DPCM_OFF_VERTICAL_POSITION    12'h008
`define DPCM_OFF_IRQ_REQUEST_READ     12'h00c
`define DPCM_OFF_IRQ_REQUEST_WRITE    12'h010
`define DPCM_OFF_IRQ_MASK             12'h014

// ************************************************
// Field positions
// ************************************************
`define DPCM_BIT_HIRES                15
`define DPCM_BIT_DUAL_FIELD_ENABLE    10
`define DPCM_BIT_PLANE_COUNT_LO       12
`define DPCM_BIT_SECOND_FIELD_FRONT   6
`define DPCM_BIT_LONG_FRAME_FLAG      15
`define DPCM_BIT_SET_CLR              15
`define DPCM_IRQ_VBLANK_MASK          16'h0020
`define DPCM_IRQ_LINE_MASK            16'h0040

// ************************************************
// Reset values and palette bases
// ************************************************
`define DPCM_RST_CONTROL              16'h0000
`define DPCM_RST_MASK                 16'h0000
`define DPCM_FIELD2_BASE              4'h8
`define DPCM_BACKGROUND_ENTRY         4'h0

`endif

// >>> core/dpcm_field_code.v
`timescale 1ns/1ps

// ************************************************
// Colour number of one playfield from its planes
// ************************************************
module dpcm_field_code (
  input  wire       plane_lo,
  input  wire       plane_mid,
  input  wire       plane_hi,
  input  wire [1:0] planes_used,
  output wire [2:0] code,
  output wire       opaque
);

  wire en_lo  = (planes_used >= 2'd1);
  wire en_mid = (planes_used >= 2'd2);
  wire en_hi  = (planes_used >= 2'd3);

  assign code   = {plane_hi & en_hi, plane_mid & en_mid, plane_lo & en_lo};
  assign opaque = |code;

endmodule

// >>> core/dpcm_color_mapper.v
`timescale 1ns/1ps
`include "dpcm_map.vh"

module dpcm_color_mapper (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  plane_bits,
  input  wire        pixel_valid,
  input  wire        sprite_opaque,
  input  wire [3:0]  sprite_entry,
  input  wire        vblank_start,
  input  wire        long_frame_in,
  input  wire [14:0] vertical_position_in,
  output reg  [3:0]  palette_index,
  output reg         palette_valid,
  output reg         field1_opaque_out,
  output reg         field2_opaque_out,
  output reg         irq
);

  // ************************************************
  // Registers
  // ************************************************
  reg [15:0] plane_control_first;
  reg [15:0] plane_control_third;
  reg [15:0] irq_status;
  reg [15:0] irq_mask;
  reg        long_frame_flag;

  wire       dual_field_enable    = plane_control_first[`DPCM_BIT_DUAL_FIELD_ENABLE];
  wire       hires                = plane_control_first[`DPCM_BIT_HIRES];
  wire [2:0] plane_count          = plane_control_first[`DPCM_BIT_PLANE_COUNT_LO+2:`DPCM_BIT_PLANE_COUNT_LO];
  wire       second_field_in_front = plane_control_third[`DPCM_BIT_SECOND_FIELD_FRONT];

  // ************************************************
  // Plane counts per playfield
  // ************************************************
  // Planes alternate between fields
  // Sum kept one bit wider so an out-of-range count of seven cannot wrap to zero
  wire [3:0] odd_sum     = {1'b0, plane_count} + 4'h1;
  wire [2:0] odd_planes  = odd_sum[3:1];
  wire [2:0] even_planes = {1'b0, plane_count[2:1]};
  reg  [1:0] field1_planes;
  reg  [1:0] field2_planes;

  always @* begin
    field1_planes = (odd_planes > 3'd3) ? 2'd3 : odd_planes[1:0];
    field2_planes = (even_planes > 3'd3) ? 2'd3 : even_planes[1:0];
    if (hires && field1_planes > 2'd2) begin
      field1_planes = 2'd2;
    end
    if (hires && field2_planes > 2'd2) begin
      field2_planes = 2'd2;
    end
  end

  wire [2:0] code1;
  wire [2:0] code2;
  wire       opaque1;
  wire       opaque2;
  wire [5:0] field_codes;
  wire [1:0] field_opaques;
  // Both counts packed so each loop pass can slice its own
  wire [3:0] field_plane_counts = {field2_planes, field1_planes};

  // ************************************************
  // Field codes
  // ************************************************
  // Field one from 1,3,5
  genvar f;
  generate
    for (f = 0; f < 2; f = f + 1) begin : g_field
      dpcm_field_code u_code (
        .plane_lo    (plane_bits[f]),
        .plane_mid   (plane_bits[f+2]),
        .plane_hi    (plane_bits[f+4]),
        .planes_used (field_plane_counts[2*f+1:2*f]),
        .code        (field_codes[3*f+2:3*f]),
        .opaque      (field_opaques[f])
      );
    end
  endgenerate

  assign code1   = field_codes[2:0];
  assign code2   = field_codes[5:3];
  assign opaque1 = field_opaques[0];
  assign opaque2 = field_opaques[1];

  // ************************************************
  // Palette selection
  // ************************************************
  // Entries 1..7 for field one
  wire [3:0] entry1 = {1'b0, code1};
  wire [3:0] entry2 = `DPCM_FIELD2_BASE | {1'b0, code2};
  // Single-field mode uses enabled planes one to four as one number
  wire [5:0] single_mask = (6'h01 << plane_count) - 6'h01;
  wire [5:0] single_code = plane_bits & single_mask;
  reg  [3:0] next_palette_index;
  reg        next_f1;
  reg        next_f2;

  // ************************************************
  // Priority
  // ************************************************
  always @* begin
    next_f1 = 1'b0;
    next_f2 = 1'b0;
    if (dual_field_enable) begin
      next_f1 = opaque1;
      next_f2 = opaque2;
      if (second_field_in_front) begin
        if (opaque2) begin
          next_palette_index = entry2;
        end else if (opaque1) begin
          next_palette_index = entry1;
        end else if (sprite_opaque) begin
          next_palette_index = sprite_entry;
        end else begin
          next_palette_index = `DPCM_BACKGROUND_ENTRY;
        end
      end else begin
        if (opaque1) begin
          next_palette_index = entry1;
        end else if (opaque2) begin
          next_palette_index = entry2;
        end else if (sprite_opaque) begin
          next_palette_index = sprite_entry;
        end else begin
          next_palette_index = `DPCM_BACKGROUND_ENTRY;
        end
      end
    end else begin
      // Sprite not used in single-field mode; full sprite priority lives elsewhere
      next_palette_index = single_code[3:0];
    end
  end

  // ************************************************
  // Pixel output stage
  // ************************************************
  // Two-bit field codes at high-res in dual-field mode only; single-field mode keeps planes one to four
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      palette_index <= 4'h0;
      palette_valid <= 1'b0;
    end else begin
      palette_index <= next_palette_index;
      palette_valid <= pixel_valid;
    end
  end

  // Field flags are qualified by valid so gaps never report a visible field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field1_opaque_out <= 1'b0;
      field2_opaque_out <= 1'b0;
    end else begin
      field1_opaque_out <= next_f1 & pixel_valid;
      field2_opaque_out <= next_f2 & pixel_valid;
    end
  end

  // ************************************************
  // APB slave
  // ************************************************
  // Decodes are qualified by the bus phase, not by the address alone
  wire        wr_access = psel & penable & pwrite;
  wire        rd_setup  = psel & ~penable & ~pwrite;
  wire [15:0] wdata16   = pwdata[15:0];
  wire [15:0] irq_clear = (wr_access && paddr == `DPCM_OFF_IRQ_REQUEST_WRITE) ? wdata16 : 16'h0000;
  wire [15:0] irq_set   = vblank_start ? `DPCM_IRQ_VBLANK_MASK : 16'h0000;
  reg  [31:0] next_prdata;
  reg         next_err;

  // ************************************************
  // Read multiplexer
  // ************************************************
  // Unmapped offsets answer with an error and zero data
  always @* begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    case (paddr)
      `DPCM_OFF_PLANE_CONTROL_FIRST: next_prdata = {16'h0000, plane_control_first};
      `DPCM_OFF_PLANE_CONTROL_THIRD: next_prdata = {16'h0000, plane_control_third};
      `DPCM_OFF_VERTICAL_POSITION:   next_prdata = {16'h0000, long_frame_flag, vertical_position_in};
      `DPCM_OFF_IRQ_REQUEST_READ:    next_prdata = {16'h0000, irq_status};
      `DPCM_OFF_IRQ_REQUEST_WRITE:   next_prdata = 32'h0000_0000;
      `DPCM_OFF_IRQ_MASK:            next_prdata = {16'h0000, irq_mask};
      default:                       next_err    = 1'b1;
    endcase
  end

  // ************************************************
  // Bus response
  // ************************************************
  // No wait state: answer prepared in setup, given in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      // Read data is frozen at setup so it cannot move while the master samples it
      if (rd_setup) begin
        prdata <= next_prdata;
      end
    end
  end

  // ************************************************
  // Control registers
  // ************************************************
  // Writes land only at the access edge where pready is seen high
  wire write_done = wr_access & pready;
  wire wr_first   = write_done & (paddr == `DPCM_OFF_PLANE_CONTROL_FIRST);
  wire wr_third   = write_done & (paddr == `DPCM_OFF_PLANE_CONTROL_THIRD);
  wire wr_mask    = write_done & (paddr == `DPCM_OFF_IRQ_MASK);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plane_control_first <= `DPCM_RST_CONTROL;
      plane_control_third <= `DPCM_RST_CONTROL;
      irq_mask            <= `DPCM_RST_MASK;
    end else begin
      if (wr_first) begin
        plane_control_first <= wdata16;
      end
      if (wr_third) begin
        plane_control_third <= wdata16;
      end
      if (wr_mask) begin
        irq_mask <= wdata16;
      end
    end
  end

  // ************************************************
  // Frame flag and interrupts
  // ************************************************
  // Set wins over clear so no blank is lost
  wire [15:0] next_irq_status = (irq_status & ~(write_done ? irq_clear : 16'h0000)) | irq_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status      <= 16'h0000;
      long_frame_flag <= 1'b0;
      irq             <= 1'b0;
    end else begin
      if (vblank_start) begin
        long_frame_flag <= long_frame_in;
      end
      irq_status <= next_irq_status;
      // Taken from the next status so the line follows the request without extra lag
      irq        <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// >>> bench/dpcm_plane_src.sv
`timescale 1ns/1ps
// ********************************************
// Bit-plane shifter stand-in
// ********************************************
module dpcm_plane_src (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [5:0] pattern,
  input  wire       show,
  output reg  [5:0] plane_bits,
  output reg        pixel_valid
);
  // Plane one on bit zero
  // Idle planes toggle every cycle so stale data never passes for a pixel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plane_bits  <= 6'h00;
      pixel_valid <= 1'b0;
    end else begin
      plane_bits  <= show ? pattern : ~plane_bits;
      pixel_valid <= show;
    end
  end
endmodule

// >>> bench/dpcm_color_mapper_chk.sv
`timescale 1ns/1ps
// ********************************************
// Port checker
// ********************************************
module dpcm_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [5:0]  plane_bits,
  input wire        pixel_valid,
  input wire        sprite_opaque,
  input wire [3:0]  sprite_entry,
  input wire        vblank_start,
  input wire [3:0]  palette_index,
  input wire        palette_valid,
  input wire        field1_opaque_out,
  input wire        field2_opaque_out,
  input wire        irq
);
  reg  [15:0] ctl1;
  reg  [15:0] ctl3;
  reg  [15:0] msk;
  wire        wdone = psel && penable && pready && pwrite;
  wire        full  = ctl1[15:10] == 6'b011001;
  wire [2:0]  fa    = {plane_bits[4], plane_bits[2], plane_bits[0]};
  wire [2:0]  fb    = {plane_bits[5], plane_bits[3], plane_bits[1]};
  // Shadows let the pixel checks know the mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1 <= 16'h0000;
      ctl3 <= 16'h0000;
      msk  <= 16'h0000;
    end else if (wdone) begin
      if (paddr == 12'h000) ctl1 <= pwdata[15:0];
      if (paddr == 12'h004) ctl3 <= pwdata[15:0];
      if (paddr == 12'h014) msk <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    penable && pready;
  endsequence
  chk_ready_pulse:
    assert property (s_setup |=> s_done ##1 !pready) else $error("pready not one pulse");
  chk_unmapped_err:
    assert property (s_setup ##0 paddr > 12'h014 |=> s_done ##0 pslverr && prdata == 32'h0) else $error("no error");
  chk_valid_follow:
    assert property (pixel_valid |=> palette_valid) else $error("palette_valid lost");
  chk_front_pick:
    assert property (pixel_valid && full && fa != 3'h0 && fb != 3'h0 |=> palette_index ==
      ($past(ctl3[6]) ? {1'b1, $past(fb)} : {1'b0, $past(fa)})) else $error("wrong front field");
  chk_clear_show:
    assert property (pixel_valid && full && fa == 3'h0 && fb == 3'h0 |=> palette_index ==
      ($past(sprite_opaque) ? $past(sprite_entry) : 4'h0)) else $error("wrong behind colour");
  chk_vblank_irq:
    assert property (vblank_start && msk[5] |=> irq) else $error("irq missing");
  chk_masked_quiet:
    assert property ((msk == 16'h0000) [*2] |-> !irq) else $error("masked irq");
  chk_clear_drop:
    assert property (wdone && paddr == 12'h010 && pwdata[5] && msk == 16'h0020 && !vblank_start
      |=> !irq) else $error("irq not cleared");
  chk_field_flags:
    assert property (pixel_valid && full |=> field1_opaque_out == ($past(fa) != 3'h0) &&
      field2_opaque_out == ($past(fb) != 3'h0)) else $error("field flag wrong");
  chk_hires_cap:
    assert property (pixel_valid && ctl1[15] && ctl1[10] && fa[1:0] == 2'h0 && fb[1:0] == 2'h0
      |=> !field1_opaque_out && !field2_opaque_out) else $error("hires plane not dropped");
  chk_plane_zero:
    assert property (pixel_valid && ctl1[10] && ctl1[14:12] == 3'h1 |=> !field2_opaque_out)
      else $error("unused plane seen");
endmodule
bind dpcm_color_mapper dpcm_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .plane_bits, .pixel_valid, .sprite_opaque, .sprite_entry, .vblank_start,
  .palette_index, .palette_valid, .field1_opaque_out, .field2_opaque_out, .irq);

// >>> bench/dpcm_color_mapper_bench.sv
`timescale 1ns/1ps
`define CK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
module dpcm_color_mapper_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg  [5:0]  pattern = 6'h00;
  reg         show = 1'b0;
  wire [5:0]  plane_bits;
  wire        pixel_valid;
  reg         sprite_opaque = 1'b0;
  reg  [3:0]  sprite_entry = 4'h5;
  reg         vblank_start = 1'b0;
  reg         long_frame_in = 1'b0;
  reg  [14:0] vertical_position_in = 15'h1234;
  wire [3:0]  palette_index;
  wire        palette_valid;
  wire        irq;
  integer     fail_count = 0;
  integer     compares = 0;
  integer     c;
  reg  [31:0] rd;
  reg         err;
  always #10 pclk = ~pclk;
  dpcm_plane_src src (.pclk, .presetn, .pattern, .show, .plane_bits, .pixel_valid);
  dpcm_color_mapper uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .plane_bits, .pixel_valid, .sprite_opaque, .sprite_entry, .vblank_start, .long_frame_in,
    .vertical_position_in, .palette_index, .palette_valid, .field1_opaque_out(), .field2_opaque_out(), .irq);
  task tally_and_finish;
    begin
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge pclk);
        i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
        fail_count++;
        tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      `CK(rd, e)
    end
  endtask
  function [3:0] exp_pix(input [6:0] v, input [2:0] n, input hr, input dl, input pr);
    reg [5:0] m;
    reg [2:0] a;
    reg [2:0] b;
    integer   i;
    begin
      for (i = 0; i < 6; i++) m[i] = v[i] && i < n && (!hr || i < 4);
      a = {m[4], m[2], m[0]};
      b = {m[5], m[3], m[1]};
      if (!dl) exp_pix = m[3:0];
      else if (pr && b != 3'h0) exp_pix = {1'b1, b};
      else if (a != 3'h0) exp_pix = {1'b0, a};
      else if (b != 3'h0) exp_pix = {1'b1, b};
      else exp_pix = v[6] ? ~v[3:0] : 4'h0;
    end
  endfunction
  task cfg(input hr, input [2:0] n, input dl, input pr);
    integer k;
    begin
      xfer(1'b1, 12'h000, {16'h0, hr, n, 1'b0, dl, 10'h0});
      xfer(1'b1, 12'h004, {25'h0, pr, 6'h0});
      rchk(12'h000, {16'h0, hr, n, 1'b0, dl, 10'h0});
      for (k = 0; k < 128; k++) begin
        @(posedge pclk);
        pattern <= k[5:0];
        sprite_opaque <= k[6];
        sprite_entry <= ~k[3:0];
        show <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        `CK(palette_index, exp_pix(k[6:0], n, hr, dl, pr))
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (c = 0; c < 24; c += 4) rchk(c[11:0], c == 8 ? {17'h0, vertical_position_in} : 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    `CK({err, rd}, 33'h100000000)
    cfg(1'b0, 3'h6, 1'b0, 1'b0);
    cfg(1'b0, 3'h6, 1'b1, 1'b0);
    cfg(1'b0, 3'h6, 1'b1, 1'b1);
    cfg(1'b1, 3'h6, 1'b1, 1'b0);
    cfg(1'b1, 3'h4, 1'b1, 1'b1);
    cfg(1'b0, 3'h3, 1'b1, 1'b0);
    cfg(1'b0, 3'h1, 1'b1, 1'b1);
    show <= 1'b0;
    @(posedge pclk);
    long_frame_in <= 1'b1;
    vblank_start <= 1'b1;
    @(posedge pclk);
    vblank_start <= 1'b0;
    rchk(12'h00c, 32'h20);
    `CK(irq, 1'b0)
    rchk(12'h008, {16'h0, 1'b1, vertical_position_in});
    xfer(1'b1, 12'h014, 32'h20);
    repeat (2) @(posedge pclk);
    #1;
    `CK(irq, 1'b1)
    xfer(1'b1, 12'h010, 32'h20);
    repeat (3) @(posedge pclk);
    #1;
    `CK(irq, 1'b0)
    rchk(12'h00c, 32'h0);
    @(posedge pclk);
    long_frame_in <= 1'b0;
    vblank_start <= 1'b1;
    @(posedge pclk);
    vblank_start <= 1'b0;
    rchk(12'h008, {17'h0, vertical_position_in});
    `CK(irq, 1'b1)
    tally_and_finish;
  end
endmodule
